/* bench/mgmt_host.sv */
// management host model issuing register reads and writes
`timescale 1ns/1ns
module mgmt_host
(
    input  wire logic        mclk,
    output logic [4:0]       regAddr,
    output logic             regWrite,
    output logic             regRead,
    output logic [15:0]      regWdata,
    input  wire logic [15:0] regRdata,
    input  wire logic        regRvalid
);
    initial
    begin
        regAddr = 5'h1F;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 16'hFFFF;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        // released lines flip so a stale value never looks valid
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge mclk);
        d = regRdata;
        v = regRvalid;
    endtask
endmodule

/* bench/phy_copper_control_register_properties.sv */
// port assertions for the phy basic control register
`timescale 1ns/1ns
module phy_copper_control_register_properties
    import phy_ctrl_pkg::*;
(
    input wire logic                 mclk,
    input wire logic                 rst_b,
    input wire logic [4:0]           regAddr,
    input wire logic                 regWrite,
    input wire logic                 regRead,
    input wire logic [15:0]          regWdata,
    input wire logic [15:0]          regRdata,
    input wire logic                 regRvalid,
    input wire logic                 stateReset,
    input wire logic                 loopbackEn,
    input wire logic                 linkBreak,
    input wire phy_ctrl_pkg::speed_t lineSpeed,
    input wire logic                 speedReserved,
    input wire logic                 anRunning,
    input wire logic                 anRestart,
    input wire logic                 powerDown
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence softRst;
        regWrite && regAddr == ADDR_BASIC_CTRL && regWdata[BIT_SW_RESET];
    endsequence
    sequence quietWr;
        regWrite && regAddr == ADDR_BASIC_CTRL && !regWdata[BIT_SW_RESET] && !regWdata[BIT_AN_RESTART];
    endsequence
    sequence restartWr;
        regWrite && regAddr == ADDR_BASIC_CTRL && regWdata[BIT_AN_RESTART] && !regWdata[BIT_SW_RESET] && !stateReset;
    endsequence
    // ten cycles held, then released
    sequence resetHeld;
        stateReset [*8] ##1 stateReset [*2] ##1 !stateReset;
    endsequence
    a_unmapped_read: assert property (regRead && regAddr == 5'h01 |=> regRvalid && regRdata == 16'h0000)
        else $error("unmapped read not answered with zero");
    a_idle_no_answer: assert property (!regRead |=> !regRvalid)
        else $error("read answer without a read");
    a_soft_hold: assert property (softRst |=> resetHeld)
        else $error("soft reset length wrong");
    a_soft_loop: assert property (softRst |=> !loopbackEn)
        else $error("loopback kept through soft reset");
    a_restart_pulse: assert property (restartWr |=> ##1 anRestart ##1 !anRestart)
        else $error("restart pulse missing or too long");
    a_reset_restart: assert property ($fell(stateReset) |=> anRestart)
        else $error("no restart after reset");
    // a write without an update event must leave the applied mode alone
    a_speed_defer: assert property (quietWr ##0 (!powerDown && !$past(powerDown) && !stateReset)
        |=> $stable(lineSpeed) && $stable(anRunning))
        else $error("speed applied without update event");
    a_loop_follow: assert property (quietWr |=> loopbackEn == $past(regWdata[BIT_LOOPBACK]))
        else $error("loopback does not follow write");
    a_link_break: assert property (linkBreak == loopbackEn)
        else $error("link not broken with loopback");
    a_gig_negotiates: assert property (lineSpeed == SPEED_1000 |-> anRunning)
        else $error("forced gigabit without negotiation");
    a_speed_reserved: assert property (speedReserved == (lineSpeed == SPEED_RSVD))
        else $error("reserved speed flag wrong");
endmodule
bind phy_copper_control_register phy_copper_control_register_properties chk
(
    .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .stateReset(stateReset),
    .loopbackEn(loopbackEn), .linkBreak(linkBreak), .lineSpeed(lineSpeed), .speedReserved(speedReserved),
    .anRunning(anRunning), .anRestart(anRestart), .powerDown(powerDown)
);

/* bench/phy_copper_control_register_tb.sv */
// self-checking bench for the phy basic control register
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errorCnt++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module phy_copper_control_register_tb;
    import phy_ctrl_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [4:0]  regAddr;
    logic        regWrite, regRead, regRvalid, v, stateReset, loopbackEn, linkBreak;
    logic        speedReserved, duplexFull, anRunning, anRestart, powerDown;
    logic [15:0] regWdata, regRdata, d;
    logic [2:0]  loopSpeed;
    logic [3:0]  advBase;
    logic [1:0]  advGig, sp;
    speed_t      lineSpeed;
    int          errorCnt = 0;
    int          checked = 0;
    int          n;
    mgmt_host host (.mclk(mclk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
    phy_copper_control_register uut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
        .stateReset(stateReset), .loopbackEn(loopbackEn), .linkBreak(linkBreak), .loopSpeed(loopSpeed),
        .lineSpeed(lineSpeed), .speedReserved(speedReserved), .duplexFull(duplexFull), .anRunning(anRunning),
        .anRestart(anRestart), .advBase(advBase), .advGig(advGig), .powerDown(powerDown));
    always #5 mclk = ~mclk;
    task automatic test_done;
        if (errorCnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // outlasts any reset timer; counts restart pulses seen
    task automatic wt;
        n = 0;
        repeat (30)
        begin
            @(posedge mclk);
            if (anRestart === 1'b1)
                n++;
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        host.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d & m, e)
    endtask
    task automatic t_reset;
        wt;
        `CHK(n, 1)
        rdc(ADDR_BASIC_CTRL, 16'hFFFF, 16'h1140);
        rdc(5'h01, 16'hFFFF, 16'h0000);
        `CHK(lineSpeed, SPEED_1000)
    endtask
    task automatic t_speed;
        host.wr(ADDR_BASIC_CTRL, 16'h3100);
        wt;
        `CHK(lineSpeed, SPEED_1000)
        for (int c = 0; c < 4; c++)
        begin
            sp = 2'(c);
            host.wr(ADDR_BASIC_CTRL, 16'h1300 | (16'(sp[0]) << 13) | (16'(sp[1]) << 6));
            wt;
            `CHK(lineSpeed, speed_t'(sp))
            `CHK(speedReserved, sp == 2'b11)
        end
    endtask
    task automatic t_forced;
        host.wr(ADDR_ADVERTISE, 16'h01E0);
        host.wr(ADDR_GIG_CTRL, 16'h0300);
        for (int f = 0; f < 2; f++)
        begin
            host.wr(ADDR_BASIC_CTRL, 16'h0240 | (16'(f) << 8));
            wt;
            `CHK({anRunning, duplexFull}, {1'b1, f[0]})
            `CHK(advGig, {f[0], ~f[0]})
            `CHK(advBase, 4'h0)
        end
        host.wr(ADDR_BASIC_CTRL, 16'h1340);
        wt;
        `CHK({advBase, advGig}, 6'h3F)
        host.wr(ADDR_BASIC_CTRL, 16'h2300);
        wt;
        `CHK(anRunning, 1'b0)
    endtask
    task automatic t_loop;
        host.wr(ADDR_PAGE, 16'h0002);
        host.wr(ADDR_MAC_CTRL2, 16'h0005);
        host.wr(ADDR_BASIC_CTRL, 16'h6100);
        @(posedge mclk);
        `CHK({loopbackEn, linkBreak}, 2'b11)
        `CHK(loopSpeed, 3'h5)
        rdc(ADDR_MAC_CTRL2, 16'hFFFF, 16'h0005);
        rdc(ADDR_ADVERTISE, 16'hFFFF, 16'h01E0);
        host.wr(ADDR_PAGE, 16'h0000);
        rdc(ADDR_MAC_CTRL2, 16'hFFFF, 16'h0000);
        host.wr(ADDR_BASIC_CTRL, 16'hE100);
        rdc(ADDR_BASIC_CTRL, 16'hE000, 16'hA000);
        `CHK({stateReset, loopbackEn}, 2'b10)
        wt;
        `CHK(n, 1)
        rdc(ADDR_BASIC_CTRL, 16'hE000, 16'h2000);
    endtask
    task automatic t_power;
        host.wr(ADDR_BASIC_CTRL, 16'h1840);
        host.wr(ADDR_COPPER_CTRL1, 16'h0004);
        host.wr(ADDR_BASIC_CTRL, 16'h1040);
        wt;
        `CHK({powerDown, lineSpeed}, {1'b1, SPEED_100})
        host.wr(ADDR_COPPER_CTRL1, 16'h0000);
        wt;
        `CHK(n, 1)
        `CHK({powerDown, lineSpeed}, {1'b0, SPEED_1000})
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset;
        t_speed;
        t_forced;
        t_loop;
        t_power;
        test_done;
    end
    // about four times the expected run length
    initial
    begin
        #20000;
        errorCnt++;
        test_done;
    end
endmodule

/* hw/phy_copper_control_register.sv */
// copper phy basic control register with deferred speed and negotiation update
//
// Notes on behaviour
// - writing bit 15 resets state machines, self-clears
// - bit 14 loops transmit to receive, breaks link
// - loopback speed comes from page-2 register 21
// - speed code bit6:bit13, 10=1000, 01=100, 11 reserved
// - speed and negotiation enable apply on update events
// - bit 12 enables negotiation, resets to one
// - loopback, speed lsb reset zero; loopback clears on soft reset
// - forced 1000 still negotiates, advertising duplex bit
// - forced 1000 ignores both advertisement fields
// - negotiation restarts after every hardware or soft reset
// - power-down exit needs both bits zero, resets, restarts
`timescale 1ns/1ns
module phy_copper_control_register
    import phy_ctrl_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire logic [4:0]           regAddr,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    input  wire logic [15:0]          regWdata,
    output logic      [15:0]          regRdata,
    output logic                      regRvalid,
    output logic                      stateReset,
    output logic                      loopbackEn,
    output logic                      linkBreak,
    output logic [2:0]                loopSpeed,
    output phy_ctrl_pkg::speed_t      lineSpeed,
    output logic                      speedReserved,
    output logic                      duplexFull,
    output logic                      anRunning,
    output logic                      anRestart,
    output logic [3:0]                advBase,
    output logic [1:0]                advGig,
    output logic                      powerDown
);
    import phy_ctrl_pkg::*;

    // software visible fields
    logic       swReset, loopback, speedLsb, anEnable, pdBasic, restartReq, duplex, speedMsb;
    logic [3:0] advField;
    logic [1:0] gigField;
    logic       pdCopper;
    logic [2:0] lbSpeed;
    logic [7:0] page;
    // applied copies, only refreshed on update events
    speed_t     actSpeed;
    logic       actAnEnable, actDuplex;
    logic       pdPrev, hwStart;

    logic       next_swReset, next_loopback, next_speedLsb, next_anEnable, next_pdBasic;
    logic       next_restartReq, next_duplex, next_speedMsb;
    logic [3:0] next_advField;
    logic [1:0] next_gigField;
    logic       next_pdCopper;
    logic [2:0] next_lbSpeed;
    logic [7:0] next_page;
    speed_t     next_actSpeed;
    logic       next_actAnEnable, next_actDuplex, next_pdPrev, next_hwStart;
    logic [15:0] next_regRdata;
    logic       next_regRvalid, next_anRestart;

    logic       wrBasic, pdNow, pdExit, resetStart, updateEvent;
    logic       timerBusy, timerDone;

    sw_reset_timer u_timer
    (
        .mclk  (mclk),
        .rst_b (rst_b),
        .start (resetStart),
        .busy  (timerBusy),
        .done  (timerDone)
    );

    function automatic logic paged_sel(input logic [4:0] a, input logic [7:0] p, input logic [4:0] t,
                                       input logic [7:0] tp);
        paged_sel = (a == t) && (p == tp);
    endfunction

    always_comb
    begin
        wrBasic = regWrite && (regAddr == ADDR_BASIC_CTRL);
        // both power-down bits must be clear
        pdNow  = pdBasic | pdCopper;
        pdExit = pdPrev && !pdNow;
        // a written one starts the reset at once
        resetStart = (wrBasic && regWdata[BIT_SW_RESET]) || pdExit || hwStart;
        // any of the four events latches the pending bits
        // the write edge of the restart bit is the event; a write in the next cycle stays pending
        updateEvent = resetStart || (wrBasic && regWdata[BIT_AN_RESTART]);
    end

    always_comb
    begin
        next_swReset    = swReset;
        next_loopback   = loopback;
        next_speedLsb   = speedLsb;
        next_anEnable   = anEnable;
        next_pdBasic    = pdBasic;
        next_restartReq = restartReq;
        next_duplex     = duplex;
        next_speedMsb   = speedMsb;
        next_advField   = advField;
        next_gigField   = gigField;
        next_pdCopper   = pdCopper;
        next_lbSpeed    = lbSpeed;
        next_page       = page;
        next_actSpeed   = actSpeed;
        next_actAnEnable = actAnEnable;
        next_actDuplex  = actDuplex;
        next_pdPrev     = pdNow;
        next_hwStart    = 1'b0;
        next_anRestart  = 1'b0;

        if (timerDone)
            next_swReset = 1'b0;
        // restart bit is serviced one cycle after it is seen
        if (restartReq)
            next_restartReq = 1'b0;
        if (wrBasic)
        begin
            // set wins over the self-clear in the same cycle
            next_swReset    = swReset | regWdata[BIT_SW_RESET] | (timerBusy & !timerDone);
            next_loopback   = regWdata[BIT_LOOPBACK];
            next_speedLsb   = regWdata[BIT_SPEED_LSB];
            next_anEnable   = regWdata[BIT_AN_ENABLE];
            next_pdBasic    = regWdata[BIT_POWER_DOWN];
            next_restartReq = regWdata[BIT_AN_RESTART];
            next_duplex     = regWdata[BIT_DUPLEX];
            next_speedMsb   = regWdata[BIT_SPEED_MSB];
            if (timerDone && !regWdata[BIT_SW_RESET])
                next_swReset = 1'b0;
        end
        if (regWrite)
        begin
            unique case (regAddr)
                ADDR_ADVERTISE: next_advField = regWdata[ADV_HI:ADV_LO];
                ADDR_GIG_CTRL:  next_gigField = regWdata[GIG_ADV_HI:GIG_ADV_LO];
                ADDR_PAGE:      next_page     = regWdata[7:0];
                default:
                begin
                    if (paged_sel(regAddr, page, ADDR_COPPER_CTRL1, PAGE_COPPER))
                        next_pdCopper = regWdata[BIT_PD_COPPER];
                    if (paged_sel(regAddr, page, ADDR_MAC_CTRL2, PAGE_MAC))
                        next_lbSpeed = regWdata[LB_SPEED_HI:0];
                end
            endcase
        end
        // power-down exit behaves as a soft reset
        if (resetStart && !wrBasic)
            next_swReset = 1'b1;
        // soft reset drops loopback, applies pending speed
        if (resetStart)
            next_loopback = 1'b0;
        if (updateEvent)
        begin
            next_actSpeed    = speed_t'({next_speedMsb, next_speedLsb});
            next_actAnEnable = next_anEnable;
            next_actDuplex   = next_duplex;
        end
        // restart negotiation when a reset ends
        if (timerDone || restartReq)
            next_anRestart = 1'b1;

        next_regRvalid = regRead;
        next_regRdata  = regRdata;
        if (regRead)
        begin
            next_regRdata = 16'h0000;
            unique case (regAddr)
                ADDR_BASIC_CTRL:
                begin
                    next_regRdata[BIT_SW_RESET]   = swReset;
                    next_regRdata[BIT_LOOPBACK]   = loopback;
                    next_regRdata[BIT_SPEED_LSB]  = speedLsb;
                    next_regRdata[BIT_AN_ENABLE]  = anEnable;
                    next_regRdata[BIT_POWER_DOWN] = pdBasic;
                    next_regRdata[BIT_AN_RESTART] = restartReq;
                    next_regRdata[BIT_DUPLEX]     = duplex;
                    next_regRdata[BIT_SPEED_MSB]  = speedMsb;
                end
                ADDR_ADVERTISE: next_regRdata[ADV_HI:ADV_LO]         = advField;
                ADDR_GIG_CTRL:  next_regRdata[GIG_ADV_HI:GIG_ADV_LO] = gigField;
                ADDR_PAGE:      next_regRdata[7:0]                   = page;
                default:
                begin
                    if (paged_sel(regAddr, page, ADDR_COPPER_CTRL1, PAGE_COPPER))
                        next_regRdata[BIT_PD_COPPER] = pdCopper;
                    if (paged_sel(regAddr, page, ADDR_MAC_CTRL2, PAGE_MAC))
                        next_regRdata[LB_SPEED_HI:0] = lbSpeed;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            swReset     <= RST_SW_RESET;
            loopback    <= RST_LOOPBACK;
            speedLsb    <= RST_SPEED_LSB;
            anEnable    <= RST_AN_ENABLE;
            pdBasic     <= RST_POWER_DN;
            restartReq  <= 1'b0;
            duplex      <= RST_DUPLEX;
            speedMsb    <= RST_SPEED_MSB;
            advField    <= RST_ADV;
            gigField    <= RST_GIG_ADV;
            pdCopper    <= RST_POWER_DN;
            lbSpeed     <= RST_LB_SPEED;
            page        <= RST_PAGE;
            actSpeed    <= speed_t'({RST_SPEED_MSB, RST_SPEED_LSB});
            actAnEnable <= RST_AN_ENABLE;
            actDuplex   <= RST_DUPLEX;
            pdPrev      <= RST_POWER_DN;
            // one reset sequence follows hardware reset
            hwStart     <= 1'b1;
            regRdata    <= 16'h0000;
            regRvalid   <= 1'b0;
            anRestart   <= 1'b0;
        end
        else
        begin
            swReset     <= next_swReset;
            loopback    <= next_loopback;
            speedLsb    <= next_speedLsb;
            anEnable    <= next_anEnable;
            pdBasic     <= next_pdBasic;
            restartReq  <= next_restartReq;
            duplex      <= next_duplex;
            speedMsb    <= next_speedMsb;
            advField    <= next_advField;
            gigField    <= next_gigField;
            pdCopper    <= next_pdCopper;
            lbSpeed     <= next_lbSpeed;
            page        <= next_page;
            actSpeed    <= next_actSpeed;
            actAnEnable <= next_actAnEnable;
            actDuplex   <= next_actDuplex;
            pdPrev      <= next_pdPrev;
            hwStart     <= next_hwStart;
            regRdata    <= next_regRdata;
            regRvalid   <= next_regRvalid;
            anRestart   <= next_anRestart;
        end
    end

    logic forcedGig;

    always_comb
    begin
        // state machines held while the timer runs
        stateReset = timerBusy;
        // loopback routes data inside and drops link
        loopbackEn = loopback;
        linkBreak  = loopback;
        // loopback speed from its own field
        loopSpeed  = lbSpeed;
        // decode of applied code; 00 is 10 Mb/s
        lineSpeed     = actSpeed;
        speedReserved = (actSpeed == SPEED_RSVD);
        duplexFull    = actDuplex;
        powerDown     = pdNow;
        forcedGig     = !actAnEnable && (actSpeed == SPEED_1000);
        if (forcedGig)
        begin
            // negotiation kept on, only matching duplex
            anRunning = 1'b1;
            advBase   = 4'h0;
            advGig    = {actDuplex, !actDuplex};
        end
        else
        begin
            anRunning = actAnEnable;
            advBase   = advField;
            advGig    = gigField;
        end
    end
endmodule

/* hw/phy_ctrl_pkg.sv */
// constants and types shared by the phy basic control logic
package phy_ctrl_pkg;
    // management register addresses and page numbers
    localparam logic [4:0]  ADDR_BASIC_CTRL   = 5'h00;
    localparam logic [4:0]  ADDR_ADVERTISE    = 5'h04;
    localparam logic [4:0]  ADDR_GIG_CTRL     = 5'h09;
    localparam logic [4:0]  ADDR_COPPER_CTRL1 = 5'h10;
    localparam logic [4:0]  ADDR_MAC_CTRL2    = 5'h15;
    localparam logic [4:0]  ADDR_PAGE         = 5'h16;
    localparam logic [4:0]  ADDR_PAGED_FIRST  = 5'h10;
    localparam logic [7:0]  PAGE_COPPER       = 8'h00;
    localparam logic [7:0]  PAGE_MAC          = 8'h02;

    // basic control field positions
    localparam int BIT_SW_RESET   = 15;
    localparam int BIT_LOOPBACK   = 14;
    localparam int BIT_SPEED_LSB  = 13;
    localparam int BIT_AN_ENABLE  = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_AN_RESTART = 9;
    localparam int BIT_DUPLEX     = 8;
    localparam int BIT_SPEED_MSB  = 6;
    // other fields
    localparam int ADV_LO         = 5;
    localparam int ADV_HI         = 8;
    localparam int GIG_ADV_LO     = 8;
    localparam int GIG_ADV_HI     = 9;
    localparam int BIT_PD_COPPER  = 2;
    localparam int LB_SPEED_HI    = 2;

    // hardware reset values
    localparam logic       RST_SW_RESET  = 1'b0;
    localparam logic       RST_LOOPBACK  = 1'b0;
    localparam logic       RST_SPEED_LSB = 1'b0;
    localparam logic       RST_AN_ENABLE = 1'b1;
    localparam logic       RST_POWER_DN  = 1'b0;
    localparam logic       RST_DUPLEX    = 1'b1;
    localparam logic       RST_SPEED_MSB = 1'b1;
    localparam logic [3:0] RST_ADV       = 4'h0;
    localparam logic [1:0] RST_GIG_ADV   = 2'h0;
    localparam logic [2:0] RST_LB_SPEED  = 3'h0;
    localparam logic [7:0] RST_PAGE      = 8'h00;

    // software reset duration
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SW_RESET_NS     = 100;
    localparam int SW_RESET_CYCLES = (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SW_RESET_CNT_W  = 8;

    // speed code, msb from bit 6 and lsb from bit 13
    typedef enum logic [1:0]
    {
        SPEED_10   = 2'b00,
        SPEED_100  = 2'b01,
        SPEED_1000 = 2'b10,
        SPEED_RSVD = 2'b11
    } speed_t;
endpackage

/* hw/sw_reset_timer.sv */
// timer that holds the phy state machines in software reset
`timescale 1ns/1ns
module sw_reset_timer
    import phy_ctrl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    typedef enum logic {IDLE, HOLD} timer_state_t;

    timer_state_t              state;
    timer_state_t              next_state;
    logic [SW_RESET_CNT_W-1:0] count;
    logic [SW_RESET_CNT_W-1:0] next_count;
    logic                      next_done;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_done  = 1'b0;
        unique case (state)
            IDLE:
            begin
                if (start)
                begin
                    next_state = HOLD;
                    next_count = SW_RESET_CNT_W'(SW_RESET_CYCLES - 1);
                end
            end
            HOLD:
            begin
                // a new start restarts the full hold time
                if (start)
                    next_count = SW_RESET_CNT_W'(SW_RESET_CYCLES - 1);
                else if (count == '0)
                begin
                    next_state = IDLE;
                    next_done  = 1'b1;
                end
                else
                    next_count = count - 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= IDLE;
            count <= '0;
            done  <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            done  <= next_done;
        end
    end

    assign busy = (state == HOLD);
endmodule
